// ### pslc_pkg.sv
// ==========================================================
// Types and constants of the port state and loopback block
// ==========================================================
package pslc_pkg;

  // Operating states, one-hot
  typedef enum logic [6:0] {
    ST_RESET = 7'b000_0001,
    ST_PLOAD = 7'b000_0010,
    ST_READY = 7'b000_0100,
    ST_RUN   = 7'b000_1000,
    ST_BUSH  = 7'b001_0000,
    ST_NETH  = 7'b010_0000,
    ST_BOTH  = 7'b100_0000
  } pslc_state_t;

  // Loop engine states, one-hot
  typedef enum logic [1:0] {
    LP_RECV = 2'b01,
    LP_SEND = 2'b10
  } pslc_lp_t;

  // Inbound byte stream
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } pslc_rx_t;

  // Outbound byte stream, tagged with its destination
  typedef struct packed {
    logic [7:0] data;
    logic       last;
    logic       to_ring;
  } pslc_out_t;

  // Frame store
  localparam int          PSLC_ADDR_W    = 11;
  localparam int          PSLC_BUF_DEPTH = 2;

  // Frame layout, byte offsets
  localparam logic [10:0] PSLC_OFF_SRC   = 11'h006;
  localparam logic [10:0] PSLC_OFF_TYPE  = 11'h00C;
  localparam logic [10:0] PSLC_OFF_TYPE1 = 11'h00D;
  localparam logic [10:0] PSLC_OFF_SKIP  = 11'h00E;
  localparam logic [10:0] PSLC_OFF_SKIP1 = 11'h00F;
  localparam logic [10:0] PSLC_OFF_FUNC  = 11'h010;
  localparam logic [10:0] PSLC_FWD_FIRST = 11'h002;
  localparam logic [10:0] PSLC_FWD_END   = 11'h008;
  localparam logic [10:0] PSLC_CRC_LEN   = 11'h004;
  localparam logic [10:0] PSLC_MIN_LEN   = 11'h012;
  localparam logic [2:0]  PSLC_ADDR_LEN  = 3'h6;

  // Field values
  localparam logic [7:0]  PSLC_TYPE_LO   = 8'h60;
  localparam logic [7:0]  PSLC_TYPE_HI   = 8'h00;
  localparam logic [15:0] PSLC_FN_REPLY  = 16'h0001;
  localparam logic [15:0] PSLC_FN_FWD    = 16'h0002;
  localparam logic [15:0] PSLC_SKIP_INC  = 16'h0008;
  localparam logic [15:0] PSLC_SKIP_MAX  = 16'h05D0;
  localparam logic [7:0]  PSLC_BCAST     = 8'hFF;

  // Block check
  localparam logic [31:0] PSLC_CRC_INIT  = 32'hFFFF_FFFF;
  localparam logic [31:0] PSLC_CRC_POLY  = 32'hEDB8_8320;
  localparam logic [31:0] PSLC_CRC_RESID = 32'hDEBB_20E3;

  // One byte of the reflected block check
  function automatic logic [31:0] pslc_crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h00_0000, d};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ PSLC_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage

// ### pslc_mem.sv
`timescale 1ns/100ps
// ==========================================================
// Frame store, registered read
// ==========================================================
module pslc_mem #(
  parameter int AW = 11,
  parameter int DW = 8
) (
  // Clock
  input  wire logic          mclk,
  // Write side
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read side
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] store [0:(1<<AW)-1];

  always_ff @(posedge mclk)
  begin
    if (we)
      store[waddr] <= wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (re)
      rdata <= store[raddr];
  end

endmodule

// ### pslc_buf.sv
`timescale 1ns/100ps
// ==========================================================
// Two-entry buffer with valid and ready on both sides
// ==========================================================
module pslc_buf (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // Filling side
  input  wire logic                 in_valid,
  input  wire pslc_pkg::pslc_out_t  in_data,
  output logic                      in_ready,
  // Draining side
  output logic                      out_valid,
  output pslc_pkg::pslc_out_t       out_data,
  input  wire logic                 out_ready
);
  import pslc_pkg::*;

  pslc_out_t e1;
  logic      v1;
  wire       push = in_valid & ~v1;
  wire       pop  = out_valid & out_ready;

  assign in_ready = ~v1;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      v1        <= 1'b0;
      out_data  <= '0;
      e1        <= '0;
    end
    else
    begin
      case ({push, pop})
        2'b10:
        begin
          if (!out_valid)
          begin
            out_data  <= in_data;
            out_valid <= 1'b1;
          end
          else
          begin
            e1 <= in_data;
            v1 <= 1'b1;
          end
        end
        2'b01:
        begin
          out_data  <= e1;
          out_valid <= v1;
          v1        <= 1'b0;
        end
        2'b11:
          out_data <= in_data;
        default:
          v1 <= v1;
      endcase
    end
  end

endmodule

// ### pslc_top.sv
`timescale 1ns/100ps
// What this block does
// - Boot command or message with switch: primary load
// - Bus halted: only boot message leads to load
// - Fatal bus, network, internal errors enter halts
// - Second fatal error in halt: combined halt
// - Bus init or driver reset: reset state
// - Leaving reset clears all internal information
// - Primary load exit set by loaded microcode
// - Start/stop; ready and running keep everything
// - Leaving single halt keeps all but ring pointers
// - Loop frame: type 60-00, own or broadcast
// - Other multicast: datagram only while running
// - Function word: 01-00 reply, 02-00 forward
// - Forward frames retransmitted, not to ring
// - Reply frames to ring, not retransmitted
// - Outbound: forward address dest, own source
// - Outbound skip count is inbound plus eight
// - Forward address only in forward frames
// - Fresh block check on retransmitted frames only, checked in
// - Loop handled locally without the driver
module pslc_top #(
  parameter int ADDR_W = pslc_pkg::PSLC_ADDR_W
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst,
  // Host commands and resets
  input  wire logic                   cmd_start,
  input  wire logic                   cmd_stop,
  input  wire logic                   cmd_boot,
  input  wire logic                   drv_reset,
  input  wire logic                   bus_init,
  // Internal events
  input  wire logic                   boot_msg,
  input  wire logic                   fatal_bus,
  input  wire logic                   fatal_net,
  input  wire logic                   fatal_int,
  input  wire logic                   selftest_ok,
  input  wire logic                   pl_exit,
  input  wire pslc_pkg::pslc_state_t  pl_target,
  // Remote boot enable switch pin
  input  wire logic                   remote_boot_sw,
  // Station address, first byte in bits 7:0
  input  wire logic [47:0]            own_addr,
  // Inbound frames from the network link
  input  wire logic                   rx_valid,
  input  wire pslc_pkg::pslc_rx_t     rx_in,
  output logic                        rx_ready,
  // Outbound bytes to transmitter or receive ring
  output logic                        out_valid,
  output pslc_pkg::pslc_out_t         out_data,
  input  wire logic                   out_ready,
  // Operating state and retention strobes
  output pslc_pkg::pslc_state_t       op_state,
  output logic                        clr_all,
  output logic                        clr_ring_ptrs
);
  import pslc_pkg::*;

  generate
    if (ADDR_W < 11 || ADDR_W > 16)
    begin : g_bad_aw
      $error("pslc_top: ADDR_W must be 11 to 16");
    end
  endgenerate

  // ==========================================================
  // Switch synchroniser
  // ==========================================================
  logic sw_meta;
  logic sw_sync;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sw_meta <= 1'b0;
      sw_sync <= 1'b0;
    end
    else
    begin
      sw_meta <= remote_boot_sw;
      sw_sync <= sw_meta;
    end
  end

  // ==========================================================
  // Operating state
  // ==========================================================
  pslc_state_t next_state;

  wire go_reset   = bus_init | drv_reset;
  wire boot_any   = (cmd_boot | boot_msg) & sw_sync;
  wire boot_remote = boot_msg & sw_sync;
  wire fatal_both = fatal_int | (fatal_bus & fatal_net);
  wire pl_tgt_ok  = (pl_target == ST_PLOAD) | (pl_target == ST_READY) |
                    (pl_target == ST_RUN) | (pl_target == ST_BUSH) |
                    (pl_target == ST_NETH) | (pl_target == ST_BOTH);

  always_comb
  begin
    next_state = op_state;
    case (op_state)
      ST_RESET:
        if (selftest_ok)
          next_state = ST_READY;
      ST_PLOAD:
        if (fatal_both)
          next_state = ST_BOTH;
        else if (fatal_bus)
          next_state = ST_BUSH;
        else if (fatal_net)
          next_state = ST_NETH;
        else if (pl_exit)
          next_state = pl_tgt_ok ? pl_target : ST_READY;
      ST_READY, ST_RUN:
        if (fatal_both)
          next_state = ST_BOTH;
        else if (fatal_bus)
          next_state = ST_BUSH;
        else if (fatal_net)
          next_state = ST_NETH;
        else if (boot_any)
          next_state = ST_PLOAD;
        else if (op_state == ST_READY && cmd_start)
          next_state = ST_RUN;
        else if (op_state == ST_RUN && cmd_stop)
          next_state = ST_READY;
      ST_BUSH:
        if (fatal_net | fatal_int)
          next_state = ST_BOTH;
        else if (boot_remote)
          next_state = ST_PLOAD;
      ST_NETH:
        if (fatal_bus | fatal_int)
          next_state = ST_BOTH;
      ST_BOTH:
        next_state = ST_BOTH;
      default:
        next_state = ST_RESET;
    endcase
    if (go_reset)
      next_state = ST_RESET;
  end

  wire moving       = next_state != op_state;
  wire next_clr_all = (op_state == ST_RESET) & moving;
  wire next_clr_rp  = ((op_state == ST_BUSH) | (op_state == ST_NETH)) & moving;

  always_ff @(posedge mclk)
  begin
    if (rst)
      op_state <= ST_RESET;
    else
      op_state <= next_state;
  end

  // Ready and running keep everything, so no strobe leaves them
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      clr_all       <= 1'b0;
      clr_ring_ptrs <= 1'b0;
    end
    else
    begin
      clr_all       <= next_clr_all;
      clr_ring_ptrs <= next_clr_rp;
    end
  end

  // ==========================================================
  // Service enables per state
  // ==========================================================
  wire loop_on = (op_state == ST_PLOAD) | (op_state == ST_READY) |
                 (op_state == ST_RUN) | (op_state == ST_BUSH);
  wire dgram_on = op_state == ST_RUN;

  // ==========================================================
  // Inbound parse
  // ==========================================================
  pslc_lp_t    lp_st;
  logic [10:0] cnt;
  logic [10:0] len;
  logic        ovf;
  logic        own_ok;
  logic        bc_ok;
  logic        mcast;
  logic        t_lo;
  logic        t_hi;
  logic [15:0] sc;
  logic [15:0] func;
  logic [47:0] fwd;
  logic [2:0]  fwd_cnt;
  logic [31:0] rx_crc;
  logic        to_ring;
  logic        rewrite;

  wire         acc       = rx_valid & rx_ready;
  wire [7:0]   b         = rx_in.data;
  wire [7:0]   own_rx    = own_addr[{cnt[2:0], 3'b000} +: 8];
  wire [10:0]  fo        = PSLC_OFF_FUNC + sc[10:0];
  wire         in_dst    = cnt < PSLC_OFF_SRC;
  wire         in_fwd    = (cnt >= fo + PSLC_FWD_FIRST) & (cnt < fo + PSLC_FWD_END);
  wire [31:0]  crc_rx_nx = pslc_crc_byte(rx_crc, b);
  wire         cnt_max   = &cnt;

  // End of frame decision
  wire [10:0]  flen      = cnt + 11'h001;
  wire         crc_good  = crc_rx_nx == PSLC_CRC_RESID;
  wire         good      = crc_good & ~ovf & (flen >= PSLC_MIN_LEN);
  wire         dst_hit   = own_ok | bc_ok;
  wire         type_ok   = t_lo & t_hi;
  wire         sc_ok     = sc <= PSLC_SKIP_MAX;
  wire         is_loop   = loop_on & dst_hit & type_ok & sc_ok;
  wire         is_reply  = is_loop & (func == PSLC_FN_REPLY) &
                           (flen >= fo + PSLC_FWD_FIRST + PSLC_CRC_LEN);
  wire         is_fwd    = is_loop & (func == PSLC_FN_FWD) &
                           (fwd_cnt == PSLC_ADDR_LEN);
  wire         is_dgram  = dgram_on & ((mcast & ~bc_ok) | (dst_hit & ~type_ok));
  wire         send_ring = good & (is_reply | is_dgram);
  wire         send_tx   = good & is_fwd;
  wire         fr_end    = acc & rx_in.last;

  always_ff @(posedge mclk)
  begin
    if (rst || fr_end)
    begin
      cnt    <= '0;
      ovf    <= 1'b0;
      rx_crc <= PSLC_CRC_INIT;
    end
    else if (acc)
    begin
      cnt    <= cnt_max ? cnt : cnt + 11'h001;
      ovf    <= ovf | cnt_max;
      rx_crc <= crc_rx_nx;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst || fr_end)
    begin
      own_ok <= 1'b1;
      bc_ok  <= 1'b1;
      mcast  <= 1'b0;
    end
    else if (acc && in_dst)
    begin
      own_ok <= own_ok & (b == own_rx);
      bc_ok  <= bc_ok & (b == PSLC_BCAST);
      mcast  <= (cnt == '0) ? b[0] : mcast;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst || fr_end)
    begin
      t_lo    <= 1'b0;
      t_hi    <= 1'b0;
      func    <= '0;
      fwd_cnt <= '0;
    end
    else if (acc)
    begin
      if (cnt == PSLC_OFF_TYPE)
        t_lo <= b == PSLC_TYPE_LO;
      if (cnt == PSLC_OFF_TYPE1)
        t_hi <= b == PSLC_TYPE_HI;
      if (cnt >= PSLC_OFF_FUNC && cnt == fo)
        func[7:0] <= b;
      if (cnt >= PSLC_OFF_FUNC && cnt == fo + 11'h001)
        func[15:8] <= b;
      if (cnt >= PSLC_OFF_FUNC && in_fwd)
        fwd_cnt <= fwd_cnt + 3'h1;
    end
  end

  // Forward address shifts in, first byte ends in bits 7:0
  // Skip count outlives frame end for the rewrite
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      fwd <= '0;
      sc  <= '0;
    end
    else if (acc)
    begin
      if (cnt == PSLC_OFF_SKIP)
        sc[7:0] <= b;
      if (cnt == PSLC_OFF_SKIP1)
        sc[15:8] <= b;
      if (cnt >= PSLC_OFF_FUNC && in_fwd)
        fwd <= {b, fwd[47:8]};
    end
  end

  // ==========================================================
  // Frame store
  // ==========================================================
  logic [ADDR_W-1:0] idx;
  logic              pend;
  logic [7:0]        mem_q;

  wire issue = (lp_st == LP_SEND) & ~pend;

  pslc_mem #(
    .AW (ADDR_W),
    .DW (8)
  ) u_mem (
    .mclk  (mclk),
    .we    (acc & ~ovf),
    .waddr (ADDR_W'(cnt)),
    .wdata (b),
    .re    (issue),
    .raddr (idx),
    .rdata (mem_q)
  );

  // ==========================================================
  // Outbound rewrite
  // ==========================================================
  logic [31:0] tx_crc;
  logic        buf_in_ready;
  pslc_out_t   buf_in;

  wire [10:0] oi        = 11'(idx);
  wire [10:0] body_len  = len - PSLC_CRC_LEN;
  wire [10:0] total     = rewrite ? len : body_len;
  wire        last_slot = oi == total - 11'h001;
  wire [15:0] sc_out    = sc + PSLC_SKIP_INC;
  wire [2:0]  src_k     = 3'(oi - PSLC_OFF_SRC);
  wire [1:0]  crc_k     = 2'(oi - body_len);
  wire [31:0] crc_fin   = ~tx_crc;
  wire [7:0]  fwd_b     = fwd[{oi[2:0], 3'b000} +: 8];
  wire [7:0]  own_b     = own_addr[{src_k, 3'b000} +: 8];
  wire [7:0]  crc_b     = crc_fin[{crc_k, 3'b000} +: 8];
  wire        in_body   = oi < body_len;
  wire        push      = pend & buf_in_ready;

  logic [7:0] out_b;

  always_comb
  begin
    out_b = mem_q;
    if (rewrite)
    begin
      if (!in_body)
        out_b = crc_b;
      else if (oi < PSLC_OFF_SRC)
        out_b = fwd_b;
      else if (oi < PSLC_OFF_TYPE)
        out_b = own_b;
      else if (oi == PSLC_OFF_SKIP)
        out_b = sc_out[7:0];
      else if (oi == PSLC_OFF_SKIP1)
        out_b = sc_out[15:8];
    end
  end

  assign buf_in.data    = out_b;
  assign buf_in.last    = last_slot;
  assign buf_in.to_ring = to_ring;

  always_ff @(posedge mclk)
  begin
    if (rst || issue && oi == '0)
      tx_crc <= PSLC_CRC_INIT;
    else if (push && in_body)
      tx_crc <= pslc_crc_byte(tx_crc, out_b);
  end

  // ==========================================================
  // Loop engine sequencing
  // ==========================================================
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      lp_st    <= LP_RECV;
      rx_ready <= 1'b1;
      len      <= '0;
      to_ring  <= 1'b0;
      rewrite  <= 1'b0;
    end
    else
    begin
      case (lp_st)
        LP_RECV:
          if (fr_end && (send_ring || send_tx))
          begin
            lp_st    <= LP_SEND;
            rx_ready <= 1'b0;
            len      <= flen;
            to_ring  <= send_ring;
            rewrite  <= send_tx;
          end
        LP_SEND:
          if (push && last_slot)
          begin
            lp_st    <= LP_RECV;
            rx_ready <= 1'b1;
          end
        default:
        begin
          lp_st    <= LP_RECV;
          rx_ready <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      idx  <= '0;
      pend <= 1'b0;
    end
    else if (issue)
      pend <= 1'b1;
    else if (push)
    begin
      pend <= 1'b0;
      idx  <= last_slot ? '0 : idx + 1'b1;
    end
  end

  // ==========================================================
  // Output buffer
  // ==========================================================
  pslc_buf u_buf (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (pend),
    .in_data   (buf_in),
    .in_ready  (buf_in_ready),
    .out_valid (out_valid),
    .out_data  (out_data),
    .out_ready (out_ready)
  );

endmodule

// ### pslc_top_sva.sv
`timescale 1ns/100ps
// ==========================================================
// Checker of the state and stream ports
// ==========================================================
module pslc_top_sva (
  // Clock and reset
  input wire logic                  mclk,
  input wire logic                  rst,
  // Events
  input wire logic                  cmd_start,
  input wire logic                  cmd_boot,
  input wire logic                  drv_reset,
  input wire logic                  bus_init,
  input wire logic                  boot_msg,
  input wire logic                  fatal_bus,
  input wire logic                  fatal_net,
  input wire logic                  fatal_int,
  // Outputs watched
  input wire logic                  out_valid,
  input wire pslc_pkg::pslc_out_t   out_data,
  input wire logic                  out_ready,
  input wire pslc_pkg::pslc_state_t op_state,
  input wire logic                  clr_all,
  input wire logic                  clr_ring_ptrs
);
  import pslc_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  logic init;
  logic quiet;
  logic live;
  assign init  = bus_init | drv_reset;
  assign quiet = !(init | fatal_bus | fatal_net | fatal_int | cmd_boot | boot_msg);
  assign live  = op_state == ST_READY || op_state == ST_RUN;
  // ==========================================================
  // Sequences
  // ==========================================================
  sequence s_ready_run;
    op_state == ST_READY ##1 op_state == ST_RUN;
  endsequence
  sequence s_reset_ready;
    op_state == ST_RESET ##1 op_state == ST_READY;
  endsequence
  sequence s_half_both;
    (op_state == ST_NETH || op_state == ST_BUSH) ##1 op_state == ST_BOTH;
  endsequence
  // ==========================================================
  // Properties
  // ==========================================================
  property p_start;
    op_state == ST_READY && cmd_start && quiet |=> op_state == ST_RUN;
  endproperty
  a_start: assert property (p_start) else $error("start missed");
  property p_init;
    init |=> op_state == ST_RESET;
  endproperty
  a_init: assert property (p_init) else $error("init missed");
  property p_both_stay;
    op_state == ST_BOTH && !init |=> op_state == ST_BOTH;
  endproperty
  a_both_stay: assert property (p_both_stay) else $error("left halt");
  property p_fatal_int;
    live && fatal_int && !init |=> op_state == ST_BOTH;
  endproperty
  a_fatal_int: assert property (p_fatal_int) else $error("internal error");
  property p_fatal_bus;
    live && fatal_bus && !fatal_net && !fatal_int && !init |=> op_state == ST_BUSH;
  endproperty
  a_fatal_bus: assert property (p_fatal_bus) else $error("bus error");
  property p_bush_boot;
    op_state == ST_BUSH && cmd_boot && !boot_msg && !fatal_net && !fatal_int && !init
      |=> op_state == ST_BUSH;
  endproperty
  a_bush_boot: assert property (p_bush_boot) else $error("boot taken");
  property p_clr_all;
    s_reset_ready |-> clr_all;
  endproperty
  a_clr_all: assert property (p_clr_all) else $error("no clear");
  property p_clr_ptrs;
    s_half_both |-> clr_ring_ptrs && !clr_all;
  endproperty
  a_clr_ptrs: assert property (p_clr_ptrs) else $error("no ptr clear");
  property p_keep;
    s_ready_run |-> !clr_all && !clr_ring_ptrs;
  endproperty
  a_keep: assert property (p_keep) else $error("state lost");
  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_data);
  endproperty
  a_hold: assert property (p_hold) else $error("byte lost");
endmodule

bind pslc_top pslc_top_sva i_pslc_top_sva (.mclk(mclk), .rst(rst), .cmd_start(cmd_start),
  .cmd_boot(cmd_boot), .drv_reset(drv_reset), .bus_init(bus_init), .boot_msg(boot_msg),
  .fatal_bus(fatal_bus), .fatal_net(fatal_net), .fatal_int(fatal_int),
  .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
  .op_state(op_state), .clr_all(clr_all), .clr_ring_ptrs(clr_ring_ptrs));

// ### pslc_sink.sv
`timescale 1ns/100ps
// ==========================================================
// Outbound sink with random stalls
// ==========================================================
module pslc_sink (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst,
  // Stream from the block
  input  wire logic                out_valid,
  input  wire pslc_pkg::pslc_out_t out_data,
  output logic                     out_ready = 1'b1,
  // Stall control
  input  wire logic                stall_en
);
  import pslc_pkg::*;
  pslc_out_t   got[$];
  logic [15:0] lfsr = 16'hACE1;
  always @(posedge mclk)
  begin
    lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    out_ready <= rst | !stall_en | lfsr[0];
    if (!rst && out_valid && out_ready)
      got.push_back(out_data);
  end
endmodule

// ### testbench.sv
`timescale 1ns/100ps
// ==========================================================
// Bench of the state and loopback block
// ==========================================================
module testbench;
  import pslc_pkg::*;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [10:0] ev = '0;
  logic        sw = 1'b1;
  logic [47:0] own;
  pslc_state_t pl_tgt = ST_RUN;
  logic        rx_valid = 1'b0;
  pslc_rx_t    rx_in = '0;
  logic        rx_ready, out_valid, out_ready, clr_all, clr_ptrs;
  logic        stall_en = 1'b0;
  pslc_out_t   out_data;
  pslc_state_t op_state;
  logic [31:0] seed = 32'hA26D_2FAC;
  int          bad_count = 0;
  int          n_checks = 0;
  logic [7:0]  fr[$];
  pslc_out_t   exq[$];
  int ev_t[32] = '{9,1,0,0,1,0,7,0,6,9,4,9,6,2,5,10,2,10,8,3,9,5,10,6,8,3,9,7,8,4,9,0};
  int st_t[32] = '{2,2,3,3,2,3,5,5,6,6,0,2,4,4,1,3,1,3,6,0,2,1,3,4,6,0,2,5,6,0,2,3};

  always #10 mclk = ~mclk;

  pslc_top i_pslc_top (.mclk(mclk), .rst(rst), .cmd_start(ev[0]), .cmd_stop(ev[1]),
    .cmd_boot(ev[2]), .drv_reset(ev[3]), .bus_init(ev[4]), .boot_msg(ev[5]),
    .fatal_bus(ev[6]), .fatal_net(ev[7]), .fatal_int(ev[8]), .selftest_ok(ev[9]),
    .pl_exit(ev[10]), .pl_target(pl_tgt), .remote_boot_sw(sw), .own_addr(own),
    .rx_valid(rx_valid), .rx_in(rx_in), .rx_ready(rx_ready), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready), .op_state(op_state), .clr_all(clr_all),
    .clr_ring_ptrs(clr_ptrs));
  pslc_sink i_pslc_sink (.mclk(mclk), .rst(rst), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready), .stall_en(stall_en));

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [7:0] rnd8();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [31:0] fcs(input logic [7:0] q[$]);
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    foreach (q[i])
    begin
      c = c ^ {24'h00_0000, q[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? ((c >> 1) ^ PSLC_CRC_POLY) : (c >> 1);
    end
    return ~c;
  endfunction
  function automatic logic [1:0] exp_clr(input int p, input int n);
    return {p == 0 && n != 0, (p == 4 || p == 5) && n != p};
  endfunction
  task automatic chk_v(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_st(input pslc_state_t g, input pslc_state_t e);
    chk_v({25'h0, g}, {25'h0, e});
  endtask
  task automatic chk_b(input pslc_out_t g, input pslc_out_t e);
    chk_v({22'h0, g}, {22'h0, e});
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic pulse(input int b, input int p, input int n);
    @(posedge mclk);
    ev <= 11'h001 << b;
    @(posedge mclk);
    ev <= '0;
    #1;
    chk_st(op_state, pslc_state_t'(7'(7'h01 << n)));
    chk_v({clr_all, clr_ptrs}, exp_clr(p, n));
    @(posedge mclk);
    #1;
    chk_v({clr_all, clr_ptrs}, 32'h0000_0000);
  endtask
  task automatic push_rnd(input int k);
    for (int i = 0; i < k; i++)
      fr.push_back(rnd8());
  endtask
  task automatic mk_frame(input bit fwd, input bit bc, input bit bad);
    logic [7:0]  ex[$];
    logic [31:0] f;
    int          s;
    int          fa;
    fr.delete();
    s = 8 * (rnd8() % 3);
    for (int i = 0; i < 6; i++)
      fr.push_back(bc ? 8'hFF : own[8*i +: 8]);
    push_rnd(6);
    fr.push_back(8'h60);
    fr.push_back(8'h00);
    fr.push_back(8'(s));
    fr.push_back(8'h00);
    push_rnd(s);
    fr.push_back(fwd ? 8'h02 : 8'h01);
    fr.push_back(8'h00);
    fa = fr.size();
    push_rnd(fwd ? 42 : 36);
    fr[fa] = fr[fa] & 8'hFE;
    f = fcs(fr) ^ {31'h0, bad};
    ex = fr;
    for (int k = 0; k < 4; k++)
      fr.push_back(f[8*k +: 8]);
    if (fwd)
    begin
      for (int i = 0; i < 6; i++)
      begin
        ex[i] = fr[fa + i];
        ex[6 + i] = own[8*i +: 8];
      end
      ex[14] = 8'(s + 8);
      f = fcs(ex);
      for (int k = 0; k < 4; k++)
        ex.push_back(f[8*k +: 8]);
    end
    if (!bad)
      foreach (ex[i])
        exq.push_back('{ex[i], i == ex.size() - 1, !fwd});
    @(posedge mclk);
    foreach (fr[i])
    begin
      rx_valid <= 1'b1;
      rx_in <= '{fr[i], i == fr.size() - 1};
      s = 0;
      @(posedge mclk);
      while (!rx_ready && s < 500)
      begin
        s++;
        @(posedge mclk);
      end
      if (s == 500)
      begin
        bad_count++;
        end_of_test();
      end
    end
    rx_valid <= 1'b0;
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    own = {rnd8(), rnd8(), rnd8(), rnd8(), rnd8(), rnd8()};
    own[0] = 1'b0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk_st(op_state, ST_RESET);
    foreach (ev_t[i])
      pulse(ev_t[i], i == 0 ? 0 : st_t[i-1], st_t[i]);
    stall_en <= 1'b1;
    for (int i = 0; i < 8; i++)
      mk_frame(i == 0 ? 1'b1 : rnd8() % 2, rnd8() % 2, i == 0);
    for (int k = 0; k < 4000 && i_pslc_sink.got.size() < exq.size(); k++)
      @(posedge mclk);
    repeat (20) @(posedge mclk);
    chk_v(i_pslc_sink.got.size(), exq.size());
    foreach (exq[i])
      if (i < i_pslc_sink.got.size())
        chk_b(i_pslc_sink.got[i], exq[i]);
    sw <= 1'b0;
    repeat (4) @(posedge mclk);
    pulse(2, 3, 3);
    end_of_test();
  end
endmodule
